/* psrw_pkg.sv */
// package for the program status word block: field layout, view codes, reset values
package psrw_pkg;

  // ================= word layout
  localparam int unsigned FLAG_N_BIT      = 31;
  localparam int unsigned FLAG_Z_BIT      = 30;
  localparam int unsigned FLAG_C_BIT      = 29;
  localparam int unsigned FLAG_V_BIT      = 28;
  localparam int unsigned FLAG_Q_BIT      = 27;
  localparam int unsigned GE_LSB          = 16;
  localparam int unsigned GE_W            = 4;
  localparam int unsigned EXC_W           = 9;
  localparam int unsigned STATE_BIT       = 24;
  localparam int unsigned XHI_LSB         = 25;
  localparam int unsigned XLO_LSB         = 10;
  localparam int unsigned RESUME_LSB      = 12;
  localparam int unsigned IDX_W           = 4;

  // ================= masks of each group inside the 32-bit word
  localparam logic [31:0] FLAGS_MASK      = 32'hF80F0000;
  localparam logic [31:0] NZCVQ_MASK      = 32'hF8000000;
  localparam logic [31:0] GE_MASK         = 32'h000F0000;
  localparam logic [31:0] EXC_MASK        = 32'h000001FF;
  localparam logic [31:0] EXEC_MASK       = 32'h0700FC00;

  // ================= reset values
  localparam logic [31:0] FLAGS_RST       = 32'h00000000;
  localparam logic [8:0]  EXC_RST         = 9'h000;
  localparam logic [1:0]  XHI_RST         = 2'h0;
  localparam logic [5:0]  XLO_RST         = 6'h00;
  localparam logic [3:0]  IDX_ZERO        = 4'h0;

  // ================= exception numbers
  localparam logic [8:0]  EXC_THREAD      = 9'h000;
  localparam logic [8:0]  EXC_NMI         = 9'h002;
  localparam logic [8:0]  EXC_HARD_FAULT  = 9'h003;
  localparam logic [8:0]  EXC_MEM_MGMT    = 9'h004;
  localparam logic [8:0]  EXC_BUS_FAULT   = 9'h005;
  localparam logic [8:0]  EXC_USAGE_FAULT = 9'h006;
  localparam logic [8:0]  EXC_SVC         = 9'h00B;
  localparam logic [8:0]  EXC_PEND_SVC    = 9'h00E;
  localparam logic [8:0]  EXC_SYS_TICK    = 9'h00F;
  localparam logic [8:0]  EXC_IRQ_BASE    = 9'h010;
  localparam logic [8:0]  EXC_MAX         = 9'h100;

  // ================= register-move view selectors
  typedef enum logic [2:0] {
    PSRW_V_FLAGS     = 3'h0,  // condition_flags
    PSRW_V_EXC       = 3'h1,  // active_exception_number
    PSRW_V_EXEC      = 3'h2,  // execution_state
    PSRW_V_FULL      = 3'h3,  // combined_status_word
    PSRW_V_EXC_EXEC  = 3'h4,  // exc_exec_view
    PSRW_V_FLAGS_EXC = 3'h5,  // flags_exc_view
    PSRW_V_FLAGS_EXE = 3'h6,  // flags_exec_view
    PSRW_V_NZCVQ     = 3'h7   // five_flag_write_view
  } psrw_view_t;

  // register-move request from the instruction pipe
  typedef struct packed {
    logic        rd;
    logic        wr;
    psrw_view_t  view;
    logic [31:0] wdata;
  } psrw_move_t;

  // execution-unit side updates
  typedef struct packed {
    logic       flags_we;
    logic [4:0] nzcvq;
    logic       ge_we;
    logic [3:0] ge;
  } psrw_alu_t;

endpackage

/* psrw_status_word.sv */
// program status word: flag, exception-number and execution-state groups
// ==================================================================
// Overview of operation
// - three disjoint groups in one 32-bit word
// - views select one, two or three groups
// - full view returns flags and exception number in place
// - writes to the exception field are discarded
// - execution bits read zero, writes ignored
// - five-flag view updates only N Z C V Q
// - N Z C V Q at bits 31..27
// - greater-or-equal flags at bits 19..16
// - 9-bit exception number at bits 8..0
// - exception numbers: 0 thread, 16+n interrupts
// - state bit at 24, rest reserved
// - shared bits hold block or resume state
// - interrupt in multi-transfer records next index
// - resume multi-transfer from stored index
// - resume state keeps 26:25, 11:10 zero
// - conditional block covers up to four instructions
// - only compact instruction-set state executes
// - state bit loaded by branch, return, vector
// - execution with state bit 0 faults
// - reset loads vector bit 0 into state bit
// ==================================================================
// field layout of the word
//   31..27 negative, zero, carry, overflow, saturation
//   26..25 shared high bits of block or resume state
//   24     instruction-set state bit
//   19..16 greater-or-equal flags
//   15..10 shared low bits, 15..12 resume index
//   8..0   active exception number
//   all other positions reserved, always zero
// ==================================================================
// view selector map
//   0 flags only, read and write
//   1 exception number only, read only
//   2 execution state only, reads zero
//   3 full word, flags writable
//   4 exception plus execution, read only, writes dropped
//   5 flags plus exception, flags writable
//   6 flags plus execution, flags writable
//   7 five flags only, greater-or-equal flags untouched
// ==================================================================
// move port usage
//   rd and wr are one-cycle levels sampled on each edge
//   read data holds until the next read request
//   a read and a write in one cycle return the old word
//   back to back requests need no gap
// ==================================================================
// update priorities
//   flags: exception return, then move write, then alu
//   state bit: reset catch, then vector, then return, then branch
//   shared bits: suspend on entry, then return, then resume ack,
//   then conditional block open, then block advance
// ==================================================================
// timing
//   move read data lands one edge after the read request
//   move write reaches status_word two edges after the request
//   every status output is one edge behind the internal state
//   state_fault follows an execution attempt by one edge
// ==================================================================
// reset
//   all groups clear while sys_rst is high
//   outputs other than state_fault read zero until the second edge after release
//   state_bit shows the caught vector bit from the second edge
// ==================================================================
// hazards and limits
//   the state bit is caught on the first edge after release,
//   so an execution attempt on that edge may raise a fault
//   the flags reset to zero to keep the word free of unknowns
//   exception numbers above the top interrupt are clipped
//   resume state is only recognised on return when the shared
//   high bits and bits 11:10 are clear and the index is nonzero
//   the conditional block and the resume index share storage, so a
//   block cannot open while a suspended transfer waits to resume
module psrw_status_word
  import psrw_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // register-move port
  input  wire psrw_move_t  move_req,
  output logic [31:0]      move_rdata,
  // execution unit updates
  input  wire psrw_alu_t   alu_upd,
  // exception entry / return
  input  wire logic        exc_entry,
  input  wire logic [8:0]  exc_entry_num,
  input  wire logic        exc_return,
  input  wire logic [8:0]  exc_return_num,
  input  wire logic [31:0] stacked_word,
  input  wire logic        vector_load,
  input  wire logic [31:0] vector_value,
  input  wire logic        reset_vec_bit0,
  // branch exchange / pop into program counter
  input  wire logic        branch_state_we,
  input  wire logic        branch_state_bit,
  // multiple transfer
  input  wire logic        multi_active,
  input  wire logic [3:0]  multi_next_idx,
  input  wire logic        multi_resume_ack,
  // conditional block
  input  wire logic        cond_block_open,
  input  wire logic [7:0]  cond_block_init,
  input  wire logic        cond_block_adv,
  // execution attempt
  input  wire logic        exec_attempt,
  // status
  output logic [31:0]      status_word,
  output logic [8:0]       exception_index,
  output logic             state_bit,
  output logic             resume_valid,
  output logic [3:0]       resume_idx,
  output logic             cond_block_active,
  output logic             state_fault
);

  // ================= storage
  logic [4:0] nzcvq_r;
  logic [3:0] greater_equal_flags_r;
  logic [8:0] exc_num_r;
  logic       state_r;
  logic [1:0] xhi_r;          // bits 26:25
  logic [5:0] xlo_r;          // bits 15:10
  logic       resume_mode_r;  // shared bits hold resume index
  logic       state_caught_r;
  logic [31:0] rdata_r;
  logic       fault_r;

  // ================= helpers
  // assemble the live word from the separate group registers
  function automatic logic [31:0] psrw_pack(
    input logic [4:0] f,
    input logic [3:0] ge,
    input logic [8:0] e,
    input logic       t,
    input logic [1:0] hi,
    input logic [5:0] lo
  );
    logic [31:0] w;
    w = 32'h00000000;
    w[FLAG_N_BIT -: 5] = f;
    w[GE_LSB +: GE_W] = ge;
    w[EXC_W-1:0] = e;
    w[STATE_BIT] = t;
    w[XHI_LSB +: 2] = hi;
    w[XLO_LSB +: 6] = lo;
    return w;
  endfunction

  function automatic logic [31:0] psrw_view_mask(input psrw_view_t v);
    logic [31:0] m;
    m = 32'h00000000;
    case (v)
      PSRW_V_FLAGS:     m = FLAGS_MASK;
      PSRW_V_EXC:       m = EXC_MASK;
      PSRW_V_EXEC:      m = EXEC_MASK;
      PSRW_V_FULL:      m = FLAGS_MASK | EXC_MASK | EXEC_MASK;
      PSRW_V_EXC_EXEC:  m = EXC_MASK | EXEC_MASK;
      PSRW_V_FLAGS_EXC: m = FLAGS_MASK | EXC_MASK;
      PSRW_V_FLAGS_EXE: m = FLAGS_MASK | EXEC_MASK;
      PSRW_V_NZCVQ:     m = NZCVQ_MASK;
      default:          m = 32'h00000000;
    endcase
    return m;
  endfunction

  logic [31:0] live_word;
  logic [31:0] wmask;
  logic        sw_flags_we;
  logic        sw_ge_we;

  assign live_word = psrw_pack(nzcvq_r, greater_equal_flags_r, exc_num_r, state_r, xhi_r, xlo_r);

  // only the flag group is writable; exception and execution bits drop out
  assign wmask = (move_req.view == PSRW_V_EXC_EXEC) ? 32'h00000000
               : (psrw_view_mask(move_req.view) & FLAGS_MASK);
  assign sw_flags_we = move_req.wr & (|(wmask & NZCVQ_MASK));
  assign sw_ge_we    = move_req.wr & (|(wmask & GE_MASK));

  // ================= condition flags; software move wins over the alu in the same cycle
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      nzcvq_r <= FLAGS_RST[FLAG_N_BIT -: 5];
      greater_equal_flags_r <= FLAGS_RST[GE_LSB +: GE_W];
    end else begin
      if (exc_return) begin
        nzcvq_r <= stacked_word[FLAG_N_BIT -: 5];
        greater_equal_flags_r <= stacked_word[GE_LSB +: GE_W];
      end else begin
        if (sw_flags_we) begin
          nzcvq_r <= move_req.wdata[FLAG_N_BIT -: 5];
        end else if (alu_upd.flags_we) begin
          nzcvq_r <= alu_upd.nzcvq;
        end
        if (sw_ge_we) begin
          greater_equal_flags_r <= move_req.wdata[GE_LSB +: GE_W];
        end else if (alu_upd.ge_we) begin
          greater_equal_flags_r <= alu_upd.ge;
        end
      end
    end
  end

  // ================= exception number; only hardware entry/return changes it
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      exc_num_r <= EXC_RST;
    end else if (exc_entry) begin
      // out-of-range numbers are clipped to the top interrupt
      exc_num_r <= (exc_entry_num > EXC_MAX) ? EXC_MAX : exc_entry_num;
    end else if (exc_return) begin
      exc_num_r <= (exc_return_num > EXC_MAX) ? EXC_MAX : exc_return_num;
    end
  end

  // ================= state bit; reset value caught after release
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= 1'b0;
      state_caught_r <= 1'b0;
    end else begin
      state_caught_r <= 1'b1;
      if (!state_caught_r) begin
        state_r <= reset_vec_bit0;
      end else if (vector_load) begin
        state_r <= vector_value[0];
      end else if (exc_return) begin
        state_r <= stacked_word[STATE_BIT];
      end else if (branch_state_we) begin
        state_r <= branch_state_bit;
      end
    end
  end

  // ================= shared execution bits: conditional block or resume index
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      xhi_r <= XHI_RST;
      xlo_r <= XLO_RST;
      resume_mode_r <= 1'b0;
    end else begin
      if (exc_entry && multi_active) begin
        // suspend the transfer, keep only the index
        xhi_r <= XHI_RST;
        xlo_r <= {multi_next_idx, 2'h0};
        resume_mode_r <= 1'b1;
      end else if (exc_return) begin
        xhi_r <= stacked_word[XHI_LSB +: 2];
        xlo_r <= stacked_word[XLO_LSB +: 6];
        // nonzero index with the other shared bits clear marks resume state
        resume_mode_r <= (stacked_word[XHI_LSB +: 2] == XHI_RST)
                       && (stacked_word[XLO_LSB +: 2] == 2'h0)
                       && (stacked_word[RESUME_LSB +: IDX_W] != IDX_ZERO);
      end else if (resume_mode_r && multi_resume_ack) begin
        xhi_r <= XHI_RST;
        xlo_r <= XLO_RST;
        resume_mode_r <= 1'b0;
      end else if (cond_block_open && !resume_mode_r) begin
        xhi_r <= cond_block_init[1:0];
        xlo_r <= cond_block_init[7:2];
      end else if (cond_block_adv && !resume_mode_r) begin
        // mask in low bits shifts; a mask of 4'h8 or an empty mask ends the block after at most four
        if (xlo_r[3:0] == 4'h8 || xlo_r[3:0] == 4'h0) begin
          xhi_r <= XHI_RST;
          xlo_r <= XLO_RST;
        end else begin
          xlo_r <= {xlo_r[5:4], xlo_r[3:0] << 1};
          xhi_r <= {xhi_r[1], xlo_r[4]};
        end
      end
    end
  end

  // ================= read data; execution bits blanked for register moves
  // the live word is read before this edge's updates, so a same-cycle write is not seen
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_r <= 32'h00000000;
    end else if (move_req.rd) begin
      rdata_r <= live_word & psrw_view_mask(move_req.view) & ~EXEC_MASK;
    end
  end

  // ================= fault on execution with the state bit clear
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fault_r <= 1'b0;
    end else begin
      fault_r <= exec_attempt && !state_r;
    end
  end

  // ================= word mirror outputs, registered
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      status_word <= 32'h00000000;
      exception_index <= EXC_RST;
      state_bit <= 1'b0;
    end else begin
      status_word <= live_word;
      exception_index <= exc_num_r;
      state_bit <= state_r;
    end
  end

  // ================= resume outputs, registered
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      resume_valid <= 1'b0;
      resume_idx <= IDX_ZERO;
    end else begin
      resume_valid <= resume_mode_r;
      resume_idx <= xlo_r[5:2];
    end
  end

  // ================= conditional block output, registered
  // a block and resume state never coexist, so resume mode masks the block flag
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cond_block_active <= 1'b0;
    end else begin
      cond_block_active <= !resume_mode_r && (xlo_r[3:0] != 4'h0);
    end
  end

  assign move_rdata = rdata_r;
  assign state_fault = fault_r;

endmodule

/* psrw_status_word_assertions.sv */
// concurrent checks on the program status word block ports
module psrw_status_word_assertions
  import psrw_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire psrw_move_t  move_req,
  input wire logic [31:0] move_rdata,
  input wire psrw_alu_t   alu_upd,
  input wire logic        exc_entry,
  input wire logic        exc_return,
  input wire logic        exec_attempt,
  input wire logic [31:0] status_word,
  input wire logic [8:0]  exception_index,
  input wire logic        state_bit,
  input wire logic        resume_valid,
  input wire logic [3:0]  resume_idx,
  input wire logic        state_fault
);
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // exec bits plus the state bit never leave through a move read
  localparam logic [31:0] XS = EXEC_MASK | 32'h01000000;
  localparam logic [31:0] LIVE = FLAGS_MASK | EXC_MASK | XS;
  // ==================== move reads
  AST_RD_EXEC: assert property (move_req.rd |=> (move_rdata & XS) == 32'h0)
    else $error("exec bits visible on move read");
  AST_RD_RSVD: assert property (move_req.rd |=> (move_rdata & ~(FLAGS_MASK | EXC_MASK)) == 32'h0)
    else $error("reserved bits set on move read");
  AST_RD_FLAGS: assert property (move_req.rd && move_req.view inside {PSRW_V_FLAGS, PSRW_V_FLAGS_EXE}
    |=> (move_rdata & ~FLAGS_MASK) == 32'h0)
    else $error("flag view carries other groups");
  AST_RD_EXC: assert property (move_req.rd && move_req.view inside {PSRW_V_EXC, PSRW_V_EXC_EXEC}
    |=> (move_rdata & ~EXC_MASK) == 32'h0)
    else $error("exception view carries other groups");
  // ==================== move writes
  AST_NZCVQ_WR: assert property (move_req.wr && move_req.view == PSRW_V_NZCVQ && !exc_return
    |-> ##2 status_word[31:27] == $past(move_req.wdata[31:27], 2))
    else $error("five flags not written");
  AST_NZCVQ_GE: assert property (move_req.wr && move_req.view == PSRW_V_NZCVQ && !exc_return && !alu_upd.ge_we
    |-> ##2 status_word[19:16] == $past(status_word[19:16]))
    else $error("ge flags changed by five flag write");
  AST_EXC_KEEP: assert property (move_req.wr && !exc_entry && !exc_return
    |-> ##2 status_word[8:0] == $past(status_word[8:0]))
    else $error("exception number written by move");
  // ==================== word layout and state
  AST_WORD_RSVD: assert property ((status_word & ~LIVE) == 32'h0)
    else $error("reserved word bits set");
  AST_IDX_MIRROR: assert property (status_word[8:0] == exception_index && status_word[24] == state_bit)
    else $error("status fields disagree with word");
  AST_RESUME: assert property (resume_valid |-> status_word[26:25] == 2'h0 && status_word[11:10] == 2'h0
    && status_word[15:12] == resume_idx)
    else $error("resume state shape wrong");
  AST_NO_FAULT: assert property (!exec_attempt |=> !state_fault)
    else $error("fault without execution");
  C_NZCVQ: cover property (move_req.wr && move_req.view == PSRW_V_NZCVQ);
  C_RESUME: cover property (resume_valid);
  C_FAULT: cover property (state_fault);
endmodule

bind psrw_status_word psrw_status_word_assertions u_psrw_status_word_assertions (.*);

/* tb_top.sv */
// self-checking bench for the program status word block
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_total++; $display("BAD %0t got %h exp %h", $time, a, b); end end
module tb_top
  import psrw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'h0, sys_rst = 1'h1, exc_entry = 1'h0, exc_return = 1'h0, vector_load = 1'h0;
  logic reset_vec_bit0 = 1'h1, branch_state_we = 1'h0, branch_state_bit = 1'h0, multi_active = 1'h0;
  logic multi_resume_ack = 1'h0, cond_block_open = 1'h0, cond_block_adv = 1'h0, exec_attempt = 1'h0;
  logic state_bit, resume_valid, cond_block_active, state_fault;
  logic [8:0] exc_entry_num = '0, exc_return_num = '0, exception_index, xm = '0;
  logic [31:0] stacked_word = '0, vector_value = '0, move_rdata, status_word, fm = '0, d;
  logic [3:0] multi_next_idx = '0, resume_idx;
  logic [7:0] cond_block_init = '0;
  psrw_move_t move_req = '0;
  psrw_alu_t alu_upd = '0, a;
  psrw_view_t v;
  integer seed = 32'hF2C23DEC;
  int err_total = 0, tests_run = 0;
  logic [8:0] codes [10] = '{EXC_NMI, EXC_HARD_FAULT, EXC_MEM_MGMT, EXC_BUS_FAULT, EXC_USAGE_FAULT,
                             EXC_SVC, EXC_PEND_SVC, EXC_SYS_TICK, EXC_IRQ_BASE, EXC_MAX};

  psrw_status_word u_psrw_status_word (.*);

  // ==================== clock, helpers, models
  always #50 core_clk = ~core_clk;
  task automatic tick(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // one move request, then two edges so writes reach status_word
  task automatic mv(logic r, logic w, psrw_view_t vv, logic [31:0] dd);
    @(posedge core_clk) move_req <= '{r, w, vv, dd};
    @(posedge core_clk) move_req <= '0;
    tick(2);
  endtask
  task automatic enter(logic [8:0] n);
    @(posedge core_clk) begin exc_entry <= 1'h1; exc_entry_num <= n; end
    @(posedge core_clk) exc_entry <= 1'h0;
    tick(2);
  endtask
  function automatic logic [31:0] wr_f(logic [31:0] f, psrw_view_t vv, logic [31:0] dd);
    if (vv == PSRW_V_NZCVQ) return (f & ~NZCVQ_MASK) | (dd & NZCVQ_MASK);
    if (vv inside {PSRW_V_FLAGS, PSRW_V_FULL, PSRW_V_FLAGS_EXC, PSRW_V_FLAGS_EXE}) return dd & FLAGS_MASK;
    return f;
  endfunction
  function automatic logic [31:0] alu_f(logic [31:0] f, psrw_alu_t u);
    if (u.flags_we) f[31:27] = u.nzcvq;
    if (u.ge_we) f[19:16] = u.ge;
    return f;
  endfunction
  // exec bits always read back as zero, so only flags and number count
  function automatic logic [31:0] rd_f(psrw_view_t vv);
    rd_f = '0;
    if (vv inside {PSRW_V_FLAGS, PSRW_V_FULL, PSRW_V_FLAGS_EXC, PSRW_V_FLAGS_EXE}) rd_f |= fm;
    if (vv inside {PSRW_V_EXC, PSRW_V_FULL, PSRW_V_EXC_EXEC, PSRW_V_FLAGS_EXC}) rd_f |= {23'h0, xm};
  endfunction
  task automatic final_report();
    $display("mismatches %0d of %0d checks", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ==================== watchdog, well beyond the few hundred cycles used
  initial begin
    #(5000 * 100);
    err_total++;
    final_report();
  end

  // ==================== main sequence
  initial begin
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'h0;
    tick(2);
    `CHK(state_bit, 1'h1)
    `CHK(exception_index, EXC_THREAD)
    foreach (codes[i]) begin
      enter(codes[i]);
      xm = codes[i];
      `CHK(exception_index, xm)
    end
    // every view written with random data, flags bumped by the alu in between
    for (int i = 0; i < 16; i++) begin
      v = psrw_view_t'(i[2:0]);
      d = $random(seed);
      mv(1'h0, 1'h1, v, d);
      fm = wr_f(fm, v, d);
      a = psrw_alu_t'(11'($random(seed)));
      @(posedge core_clk) alu_upd <= a;
      @(posedge core_clk) alu_upd <= '0;
      fm = alu_f(fm, a);
      v = psrw_view_t'(3'(i % 7));
      mv(1'h1, 1'h0, v, '0);
      `CHK(move_rdata, rd_f(v))
    end
    `CHK(status_word & (FLAGS_MASK | EXC_MASK), fm | {23'h0, xm})
    @(posedge core_clk) begin cond_block_open <= 1'h1; cond_block_init <= 8'h08; end
    @(posedge core_clk) cond_block_open <= 1'h0;
    tick(2);
    `CHK(cond_block_active, 1'h1)
    `CHK(status_word[15:10], 6'h02)
    @(posedge core_clk) cond_block_adv <= 1'h1;
    @(posedge core_clk) cond_block_adv <= 1'h0;
    tick(2);
    `CHK(status_word[15:10], 6'h04)
    mv(1'h1, 1'h0, PSRW_V_EXEC, '0);
    `CHK(move_rdata, 32'h0)
    // interrupt in mid multi-transfer, then return and resume
    @(posedge core_clk) begin multi_active <= 1'h1; multi_next_idx <= 4'h5; end
    enter(EXC_IRQ_BASE);
    `CHK(resume_valid, 1'h1)
    `CHK(resume_idx, 4'h5)
    `CHK(status_word[26:25], 2'h0)
    @(posedge core_clk) begin multi_active <= 1'h0; exc_return <= 1'h1; stacked_word <= 32'hA1005000; end
    @(posedge core_clk) exc_return <= 1'h0;
    tick(2);
    `CHK(status_word, 32'hA1005000)
    @(posedge core_clk) multi_resume_ack <= 1'h1;
    @(posedge core_clk) multi_resume_ack <= 1'h0;
    tick(2);
    `CHK(resume_valid, 1'h0)
    // vector clears the state bit, execution then faults until a branch sets it
    @(posedge core_clk) begin vector_load <= 1'h1; vector_value <= 32'h00000100; end
    @(posedge core_clk) begin vector_load <= 1'h0; exec_attempt <= 1'h1; end
    tick(2);
    `CHK(state_bit, 1'h0)
    `CHK(state_fault, 1'h1)
    @(posedge core_clk) begin branch_state_we <= 1'h1; branch_state_bit <= 1'h1; end
    @(posedge core_clk) branch_state_we <= 1'h0;
    tick(2);
    `CHK(state_bit, 1'h1)
    `CHK(state_fault, 1'h0)
    final_report();
  end
endmodule
